// file: design/tio_pkg.sv
// Summary of operation
// - Five ports of 1, 4, 8, 16 and 32 pins sit on the tile.
// - All pins of one port share one direction, input or output.
// - A port drives or samples its pins, optionally waiting on a pin condition when sampling.
// - Each processor access to a port completes in one bus transfer.
// - Open-drain output pulls low for zero and floats for one.
// - Open-drain is chosen per port and covers all its pins.
// - Data passes through a serialiser stage plus a transfer register.
// - Each port has a 16-bit counter that can time pin transfers.
// - Counter is always readable and can delay I/O until a set value.
// - Each transfer captures the counter as a readable timestamp.
// - An enabled serial link disconnects the ports from its shared pins.
// - An enabled narrower port takes shared pins from wider ports.
// - Unshared pins of a wider port stay with the wider port.
// - A port always transfers at its own full width.
// - Six clock blocks; block 0 is the tile reference clock.
// - Clock blocks 1 to 5 can run at other rates by division.
// - A clock block can take the 1-bit port pin as its source.
// - A clock block can divide its 1-bit port source.
// - A port can qualify sampled input with an incoming strobe.
// - A port can emit an outgoing strobe alongside driven data.
// - After reset every port uses clock block 0.
// - Pin-condition events go straight out as event pulses, no interrupt.
package tio_pkg;
  localparam int NUM_PORTS = 5;
  localparam int NUM_CB = 6;
  localparam int NUM_PINS = 32;
  localparam int PORT_W [NUM_PORTS] = '{1, 4, 8, 16, 32};
  // Pins shared with the inter-device link
  localparam int LINK_PIN_LO = 16;
  localparam int LINK_PIN_HI = 25;
  // Address map: ports at 0x000 + 0x20*k, clock blocks at 0x100 + 4*n
  localparam logic [11:0] CB_BASE = 12'h100;
  localparam logic [2:0] OFF_CTRL = 3'h0;
  localparam logic [2:0] OFF_DATA = 3'h1;
  localparam logic [2:0] OFF_COND = 3'h2;
  localparam logic [2:0] OFF_TIME = 3'h3;
  localparam logic [2:0] OFF_CNT = 3'h4;
  localparam logic [2:0] OFF_TSTAMP = 3'h5;
  localparam logic [2:0] OFF_STAT = 3'h6;
  // Condition modes
  localparam logic [1:0] COND_NONE = 2'h0;
  localparam logic [1:0] COND_EQ = 2'h1;
  localparam logic [1:0] COND_NE = 2'h2;
  // Clock block field positions
  localparam int CB_SRC_BIT = 0;
  localparam int CB_DIV_BIT = 1;
  localparam int CB_DIVISOR_LSB = 8;
  localparam logic [7:0] CB_DIVISOR_RST = 8'h00;
  localparam logic [2:0] CB_REF = 3'h0;

  typedef struct packed {
    logic [2:0] clk_sel;
    logic strobe_out_en;
    logic strobe_in_en;
    logic timed;
    logic [1:0] cond_mode;
    logic open_drain;
    logic dir_out;
    logic enable;
  } tio_ctrl_t;

  localparam tio_ctrl_t CTRL_RST = '{clk_sel: CB_REF, default: 1'b0};
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
endpackage

// file: design/tio_port_block.sv
`timescale 1ns/10ps
`default_nettype none
module tio_port_block
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link ownership of shared pins
  input wire logic link_active,
  // Pins
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe_n,
  // Strobes and events
  input wire logic [4:0] strobe_in_qualifier,
  output logic [4:0] strobe_out_marker,
  output logic [4:0] port_event
);
  localparam int NP = tio_pkg::NUM_PORTS;

  logic [31:0] pin_meta_reg, pin_sync_reg;
  logic [4:0] stb_meta_reg, stb_sync_reg;
  logic ref_pin_prev_reg;
  logic [31:0] link_mask;
  logic [31:0] pins_avail;
  logic [5:0] cb_tick;
  logic [31:0] cb_cfg_reg [tio_pkg::NUM_CB];
  tio_pkg::tio_ctrl_t ctrl_reg [NP];
  logic [31:0] cond_reg [NP];
  logic [15:0] time_reg [NP];
  logic [31:0] rx_reg [NP];
  logic [15:0] cnt_reg [NP];
  logic [15:0] tstamp_reg [NP];
  logic [1:0] stat [NP];
  logic [31:0] drv_reg [NP];
  logic [NP-1:0] drives;
  logic setup, access, wr_acc, rd_acc;
  logic cb_sel, port_sel, mapped;
  logic [2:0] port_idx;
  logic [2:0] reg_off;
  logic [2:0] cb_idx;
  logic [31:0] rd_mux;

  // Two-stage sync on everything from the pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_reg <= 32'h0000_0000;
      pin_sync_reg <= 32'h0000_0000;
      stb_meta_reg <= 5'h00;
      stb_sync_reg <= 5'h00;
    end
    else if (clk_en)
    begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
      stb_meta_reg <= strobe_in_qualifier;
      stb_sync_reg <= stb_meta_reg;
    end
  end

  always_comb
  begin
    link_mask = 32'h0000_0000;
    for (int p = tio_pkg::LINK_PIN_LO; p <= tio_pkg::LINK_PIN_HI; p++)
    begin
      link_mask[p] = link_active;
    end
  end

  // Link-owned pins read as zero to the ports
  assign pins_avail = pin_sync_reg & ~link_mask;

  // APB decode
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = access;
  assign port_idx = paddr[7:5];
  assign reg_off = paddr[4:2];
  assign cb_idx = paddr[4:2];

  always_comb
  begin
    cb_sel = 1'b0;
    port_sel = 1'b0;
    if (paddr[1:0] != 2'h0)
    begin
      cb_sel = 1'b0;
    end
    else if (paddr[11:5] == tio_pkg::CB_BASE[11:5])
    begin
      cb_sel = (cb_idx < 3'(tio_pkg::NUM_CB));
    end
    else if (paddr[11:8] == 4'h0)
    begin
      port_sel = (port_idx < 3'(NP)) && (reg_off <= tio_pkg::OFF_STAT);
    end
  end

  assign mapped = cb_sel || port_sel;
  assign wr_acc = access && pwrite && mapped;
  assign rd_acc = access && !pwrite && mapped;
  assign pslverr = access && !mapped;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (cb_sel)
    begin
      rd_mux = cb_cfg_reg[cb_idx];
    end
    else if (port_sel)
    begin
      if (reg_off == tio_pkg::OFF_CTRL)
        rd_mux = 32'(ctrl_reg[port_idx]);
      else if (reg_off == tio_pkg::OFF_DATA)
        rd_mux = rx_reg[port_idx];
      else if (reg_off == tio_pkg::OFF_COND)
        rd_mux = cond_reg[port_idx];
      else if (reg_off == tio_pkg::OFF_TIME)
        rd_mux = {16'h0000, time_reg[port_idx]};
      else if (reg_off == tio_pkg::OFF_CNT)
        rd_mux = {16'h0000, cnt_reg[port_idx]};
      else if (reg_off == tio_pkg::OFF_TSTAMP)
        rd_mux = {16'h0000, tstamp_reg[port_idx]};
      else
        rd_mux = {30'h0000_0000, stat[port_idx]};
    end
  end

  // Read data caught in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (clk_en && setup && !pwrite)
      prdata <= rd_mux;
  end

  // Clock blocks: pacing ticks on pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ref_pin_prev_reg <= 1'b0;
    else if (clk_en)
      ref_pin_prev_reg <= pins_avail[0];
  end

  assign cb_tick[0] = 1'b1;

  genvar c;
  generate
    for (c = 0; c < tio_pkg::NUM_CB; c++)
    begin : g_cb
      logic [7:0] div_cnt_reg;
      logic src_evt;
      logic [7:0] divisor;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          cb_cfg_reg[c] <= 32'h0000_0000;
        else if (clk_en && wr_acc && cb_sel && cb_idx == 3'(c) && c != 0)
          cb_cfg_reg[c] <= {16'h0000, pwdata[15:8], 6'h00, pwdata[1:0]};
      end
      assign divisor = cb_cfg_reg[c][tio_pkg::CB_DIVISOR_LSB +: 8];
      // Rising edge of the 1-bit port pin, or the reference clock
      assign src_evt = cb_cfg_reg[c][tio_pkg::CB_SRC_BIT] ?
                       (pins_avail[0] && !ref_pin_prev_reg) : 1'b1;
      if (c != 0)
      begin : g_div
        always_ff @(posedge pclk or negedge presetn)
        begin
          if (!presetn)
            div_cnt_reg <= tio_pkg::CB_DIVISOR_RST;
          else if (clk_en && src_evt)
          begin
            if (div_cnt_reg >= divisor)
              div_cnt_reg <= 8'h00;
            else
              div_cnt_reg <= div_cnt_reg + 8'h01;
          end
        end
        // Divide by divisor+1 when enabled
        assign cb_tick[c] = src_evt && (!cb_cfg_reg[c][tio_pkg::CB_DIV_BIT] ||
                            div_cnt_reg >= divisor);
      end
      else
      begin : g_ref
        assign div_cnt_reg = 8'h00;
      end
    end
  endgenerate

  // Ports
  genvar k;
  generate
    for (k = 0; k < NP; k++)
    begin : g_port
      localparam int W = tio_pkg::PORT_W[k];
      localparam logic [5:0] CHUNKS = 6'(32 / W);
      logic [31:0] sr_reg;
      logic [31:0] tx_reg;
      logic tx_full_reg, rx_valid_reg, busy_reg, stb_out_reg, evt_reg;
      logic [5:0] left_reg;
      logic [5:0] got_reg;
      logic [31:0] pins_w;
      logic tick, time_ok, cond_ok, strobe_ok, load, out_step, in_step, cond_hit, word_done;
      logic my_wr, data_rd;

      assign pins_w = pins_avail & ((W == 32) ? 32'hffff_ffff : ((32'h1 << W) - 32'h1));
      assign tick = ctrl_reg[k].enable && ctrl_reg[k].clk_sel < 3'(tio_pkg::NUM_CB) &&
                    cb_tick[ctrl_reg[k].clk_sel];
      assign time_ok = !ctrl_reg[k].timed || cnt_reg[k] == time_reg[k];
      assign strobe_ok = !ctrl_reg[k].strobe_in_en || stb_sync_reg[k];
      always_comb
      begin
        case (ctrl_reg[k].cond_mode)
          tio_pkg::COND_EQ: cond_ok = pins_w == cond_reg[k];
          tio_pkg::COND_NE: cond_ok = pins_w != cond_reg[k];
          default: cond_ok = 1'b1;
        endcase
      end
      assign load = tick && ctrl_reg[k].dir_out && !busy_reg && tx_full_reg && time_ok;
      assign out_step = tick && ctrl_reg[k].dir_out && busy_reg;
      assign in_step = tick && !ctrl_reg[k].dir_out && strobe_ok &&
                       (got_reg != 6'h00 || time_ok);
      assign cond_hit = in_step && ctrl_reg[k].cond_mode != tio_pkg::COND_NONE && cond_ok;
      assign word_done = in_step && ctrl_reg[k].cond_mode == tio_pkg::COND_NONE &&
                         got_reg == CHUNKS - 6'h01;
      assign my_wr = wr_acc && port_sel && port_idx == 3'(k);
      assign data_rd = rd_acc && port_sel && port_idx == 3'(k) && reg_off == tio_pkg::OFF_DATA;
      assign stat[k] = {tx_full_reg, rx_valid_reg};
      assign drives[k] = ctrl_reg[k].enable && ctrl_reg[k].dir_out;

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          ctrl_reg[k] <= tio_pkg::CTRL_RST;
          cond_reg[k] <= tio_pkg::WORD_RST;
          time_reg[k] <= tio_pkg::CNT_RST;
        end
        else if (clk_en && my_wr)
        begin
          if (reg_off == tio_pkg::OFF_CTRL)
            ctrl_reg[k] <= tio_pkg::tio_ctrl_t'(pwdata[10:0]);
          else if (reg_off == tio_pkg::OFF_COND)
            cond_reg[k] <= pwdata;
          else if (reg_off == tio_pkg::OFF_TIME)
            time_reg[k] <= pwdata[15:0];
        end
      end

      // Port counter
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          cnt_reg[k] <= tio_pkg::CNT_RST;
        else if (clk_en && tick)
          cnt_reg[k] <= cnt_reg[k] + 16'h0001;
      end

      // Transfer register, write side; a new write wins over the load
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          tx_reg <= tio_pkg::WORD_RST;
          tx_full_reg <= 1'b0;
        end
        else if (clk_en)
        begin
          if (my_wr && reg_off == tio_pkg::OFF_DATA)
          begin
            tx_reg <= pwdata;
            tx_full_reg <= 1'b1;
          end
          else if (load)
            tx_full_reg <= 1'b0;
        end
      end

      // Serialiser stage, shared by both directions
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sr_reg <= tio_pkg::WORD_RST;
          busy_reg <= 1'b0;
          left_reg <= 6'h00;
          got_reg <= 6'h00;
        end
        else if (clk_en)
        begin
          if (load)
          begin
            sr_reg <= tx_reg;
            busy_reg <= 1'b1;
            left_reg <= CHUNKS;
          end
          else if (out_step)
          begin
            sr_reg <= sr_reg >> W;
            left_reg <= left_reg - 6'h01;
            busy_reg <= left_reg != 6'h01;
          end
          else if (in_step && ctrl_reg[k].cond_mode == tio_pkg::COND_NONE)
          begin
            // New chunk enters at the top; first chunk ends at the bottom
            sr_reg <= (sr_reg >> W) | (pins_w << (32 - W));
            got_reg <= word_done ? 6'h00 : got_reg + 6'h01;
          end
        end
      end

      // Receive side, timestamp, strobes and events
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          rx_reg[k] <= tio_pkg::WORD_RST;
          rx_valid_reg <= 1'b0;
          tstamp_reg[k] <= tio_pkg::CNT_RST;
          drv_reg[k] <= tio_pkg::WORD_RST;
          stb_out_reg <= 1'b0;
          evt_reg <= 1'b0;
        end
        else if (clk_en)
        begin
          stb_out_reg <= out_step && ctrl_reg[k].strobe_out_en;
          evt_reg <= cond_hit;
          if (out_step)
            drv_reg[k] <= sr_reg & pins_mask(W);
          if (load || cond_hit || word_done)
            tstamp_reg[k] <= cnt_reg[k];
          if (cond_hit)
            rx_reg[k] <= pins_w;
          else if (word_done)
            rx_reg[k] <= (sr_reg >> W) | (pins_w << (32 - W));
          // Arrival wins over a clearing read in the same cycle
          if (cond_hit || word_done)
            rx_valid_reg <= 1'b1;
          else if (data_rd)
            rx_valid_reg <= 1'b0;
        end
      end

      assign strobe_out_marker[k] = stb_out_reg;
      assign port_event[k] = evt_reg;
    end
  endgenerate

  function automatic logic [31:0] pins_mask(input int w);
    pins_mask = (w >= 32) ? 32'hffff_ffff : ((32'h1 << w) - 32'h1);
  endfunction

  // Pin ownership: widest first so narrower enabled ports override
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= 32'h0000_0000;
      pin_oe_n <= 32'hffff_ffff;
    end
    else if (clk_en)
    begin
      for (int p = 0; p < tio_pkg::NUM_PINS; p++)
      begin
        logic drv_en;
        logic val;
        logic od;
        drv_en = 1'b0;
        val = 1'b0;
        od = 1'b0;
        for (int j = NP - 1; j >= 0; j--)
        begin
          if (ctrl_reg[j].enable && p < tio_pkg::PORT_W[j])
          begin
            drv_en = drives[j];
            val = drv_reg[j][p];
            od = ctrl_reg[j].open_drain;
          end
        end
        if (link_mask[p])
          drv_en = 1'b0;
        if (od)
        begin
          pin_out[p] <= 1'b0;
          pin_oe_n[p] <= !(drv_en && !val);
        end
        else
        begin
          pin_out[p] <= val;
          pin_oe_n[p] <= !drv_en;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/tio_port_block_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module tio_port_checker
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and strobes
  input wire logic link_active,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe_n,
  input wire logic [4:0] strobe_out_marker,
  input wire logic [4:0] port_event
);
  logic rd_setup;
  assign rd_setup = psel && !penable && !pwrite;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_access;
    psel && penable;
  endsequence
  // Earliest write lands two edges after release, so no pin moves before
  sequence s_pins_idle;
    (&pin_oe_n)[*3];
  endsequence

  a_ready_access: assert property (s_access |-> pready)
    else $error("pready low in access phase");
  a_ready_idle: assert property (!(psel && penable) |-> !pready && !pslverr)
    else $error("pready or pslverr outside access phase");
  a_rdata_err: assert property (s_access ##0 (pslverr && !pwrite) |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_rdata_hold: assert property (!$past(rd_setup) |-> $stable(prdata))
    else $error("prdata moved without a read setup");
  a_reset_quiet: assert property ($rose(presetn) |->
    &pin_oe_n && pin_out == 32'h0 && port_event == 5'h0 && strobe_out_marker == 5'h0)
    else $error("outputs not quiet after reset");
  a_idle_pins: assert property ($rose(presetn) |-> s_pins_idle)
    else $error("pin driven before any port was set up");
  a_link_release: assert property ($past(link_active) && $past(clk_en) |->
    &pin_oe_n[25:16])
    else $error("port drives a link pin");
  a_strobe_drive: assert property (strobe_out_marker[4] && clk_en |=>
    pin_oe_n != 32'hffff_ffff)
    else $error("strobe without driven data");
endmodule

bind tio_port_block tio_port_checker u_chk
(
  .pclk(pclk),
  .presetn(presetn),
  .clk_en(clk_en),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .link_active(link_active),
  .pin_out(pin_out),
  .pin_oe_n(pin_oe_n),
  .strobe_out_marker(strobe_out_marker),
  .port_event(port_event)
);
`default_nettype wire

// file: tb/tio_pin_partner.sv
`timescale 1ns/10ps
`default_nettype none
module tio_pin_partner
(
  // Device side
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe_n,
  output logic [31:0] pin_in,
  // Board drivers
  input wire logic [31:0] ext_en,
  input wire logic [31:0] ext_val
);
  // Board pull-ups, so a released open-drain line reads high
  always_comb
  begin
    for (int i = 0; i < 32; i++)
    begin
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule
`default_nettype wire

// file: tb/tio_port_block_bench.sv
`timescale 1ns/10ps
`default_nettype none
module tio_port_block_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic link_active = 1'b0;
  logic [4:0] strobe_in_qualifier = 5'h00;
  logic [31:0] ext_en = 32'h0;
  logic [31:0] ext_val = 32'h0;
  logic [31:0] prdata, pin_in, pin_out, pin_oe_n, w, v, r0, r1;
  int n = 0;
  logic [4:0] strobe_out_marker, port_event;
  logic pready, pslverr, seen;
  logic [33:0] exp_q[$];
  logic [33:0] nq;
  int err_count = 0;
  int cmp_count = 0;
  int cm[5] = '{9, 9, 17, 17, 1};
  int cv[5] = '{0, 6, 6, 3, 6};
  int ce[5] = '{0, 1, 0, 1, 0};

  always #10 pclk = ~pclk;

  tio_port_block dut
  (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .link_active(link_active),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .strobe_in_qualifier(strobe_in_qualifier),
    .strobe_out_marker(strobe_out_marker),
    .port_event(port_event)
  );

  tio_pin_partner u_board
  (
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .pin_in(pin_in),
    .ext_en(ext_en),
    .ext_val(ext_val)
  );

  task automatic chk(input string what, input logic [32:0] seen_v, input logic [32:0] exp_v);
    cmp_count++;
    if (seen_v !== exp_v)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp_v, seen_v);
    end
  endtask

  // Top bit of a note says whether the read has a known answer
  task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d,
                     input logic [33:0] e, output logic [31:0] r);
    if (!wr_en)
      exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, 34'h0, r);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, {1'b1, e}, r);
  endtask

  // Counter loads are eight cycles apart
  task automatic cnt_step(input logic [11:0] a, input logic [15:0] e);
    logic [31:0] r0, r1;
    apb(1'b0, a, 32'h0, 34'h0, r0);
    repeat (5) @(posedge pclk);
    apb(1'b0, a, 32'h0, 34'h0, r1);
    chk("count step", 33'(r1[15:0] - r0[15:0]), 33'(e));
  endtask

  task automatic end_of_test();
    $display("Compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    if (psel && penable && !pwrite && pready === 1'b1)
    begin
      nq = exp_q.pop_front();
      if (nq[33])
        chk("read", {pslverr, prdata}, nq[32:0]);
    end
  end

  initial
  begin
    repeat (5000) @(posedge pclk);
    err_count++;
    end_of_test();
  end

  initial
  begin
    void'($urandom(18997));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 5; k++)
      rd(12'(32 * k), 33'h0);
    rd(12'h018, 33'h0);
    rd(12'h01c, 33'h1_0000_0000);
    $display("test reset done");
    w = $urandom() & 32'hffff_fffe;
    wr(12'h080, 32'h83);
    wr(12'h084, w);
    wr(12'h000, 32'h03);
    wr(12'h004, 32'hffff_ffff);
    repeat (4) @(posedge pclk);
    chk("pin_out", 33'(pin_out), 33'(w | 32'h1));
    chk("pin_oe_n", 33'(pin_oe_n), 33'h0);
    cnt_step(12'h010, 16'd8);
    link_active <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("link oe", 33'(pin_oe_n[25:16]), 33'h3ff);
    chk("upper pins", 33'(pin_out[31:26]), 33'(w[31:26]));
    link_active <= 1'b0;
    $display("test output done");
    wr(12'h080, 32'h0);
    wr(12'h000, 32'h0);
    wr(12'h040, 32'h07);
    wr(12'h044, 32'ha5a5_a5a5);
    repeat (8) @(posedge pclk);
    chk("od oe", 33'(pin_oe_n), 33'hffff_ffa5);
    chk("od out", 33'(pin_out[7:0]), 33'h0);
    $display("test open drain done");
    v = $urandom();
    ext_en <= 32'h0000_ffff;
    ext_val <= v;
    wr(12'h040, 32'h0);
    wr(12'h060, 32'h01);
    repeat (8) @(posedge pclk);
    rd(12'h078, 33'h1);
    rd(12'h064, 33'({v[15:0], v[15:0]}));
    wr(12'h060, 32'h0);
    wr(12'h028, 32'h6);
    for (int r = 0; r < 5; r++)
    begin
      ext_val <= 32'(cv[r]);
      wr(12'h020, 32'(cm[r]));
      repeat (4) @(posedge pclk);
      seen = 1'b0;
      repeat (8)
      begin
        @(posedge pclk);
        seen |= port_event[1];
      end
      chk("event", 33'(seen), 33'(ce[r]));
    end
    $display("test input done");
    wr(12'h100, 32'h302);
    rd(12'h100, 33'h0);
    wr(12'h104, 32'h302);
    rd(12'h104, 33'h302);
    wr(12'h000, 32'h101);
    cnt_step(12'h010, 16'd2);
    $display("test clock blocks done");
    // Stale word from the input test is drained before the strobe gates sampling
    wr(12'h060, 32'h41);
    rd(12'h064, 33'({v[15:0], v[15:0]}));
    repeat (8) @(posedge pclk);
    rd(12'h078, 33'h0);
    strobe_in_qualifier <= 5'h08;
    repeat (8) @(posedge pclk);
    rd(12'h078, 33'h1);
    rd(12'h064, 33'h0_0006_0006);
    strobe_in_qualifier <= 5'h00;
    wr(12'h060, 32'h0);
    wr(12'h020, 32'h0);
    $display("test strobe in done");
    wr(12'h000, 32'h0);
    wr(12'h080, 32'ha3);
    apb(1'b0, 12'h090, 32'h0, 34'h0, r0);
    w = r0 + 32'd40;
    wr(12'h08c, {16'h0000, w[15:0]});
    v = $urandom();
    wr(12'h084, v);
    n = 0;
    repeat (60)
    begin
      @(posedge pclk);
      n += strobe_out_marker[4];
    end
    chk("strobe out", 33'(n), 33'h1);
    chk("timed out", 33'(pin_out), 33'(v));
    rd(12'h094, 33'(w[15:0]));
    $display("test timed output done");
    apb(1'b0, 12'h090, 32'h0, 34'h0, r0);
    clk_en <= 1'b0;
    repeat (10) @(posedge pclk);
    clk_en <= 1'b1;
    apb(1'b0, 12'h090, 32'h0, 34'h0, r1);
    chk("frozen count", 33'(r1[15:0] - r0[15:0]), 33'h3);
    $display("test clock enable done");
    wr(12'h080, 32'h0);
    wr(12'h108, 32'h1);
    wr(12'h040, 32'h201);
    apb(1'b0, 12'h050, 32'h0, 34'h0, r0);
    repeat (3)
    begin
      ext_val <= 32'h1;
      repeat (4) @(posedge pclk);
      ext_val <= 32'h0;
      repeat (4) @(posedge pclk);
    end
    apb(1'b0, 12'h050, 32'h0, 34'h0, r1);
    chk("pin clock", 33'(r1[15:0] - r0[15:0]), 33'h3);
    $display("test pin clock done");
    repeat (2) @(posedge pclk);
    end_of_test();
  end
endmodule
`default_nettype wire
